// ---- src/synth_divider_status_mux.sv ----
// Control and status logic of the fractional-N synthesizer: oscillator
// control, divided reference output, reference and feedback dividers,
// chip-enable clearing and the multiplexed status output.
// Assumes CLK_SYS is the reference clock and the analog indications
// arrive synchronous to it; only CHIP_ENABLE comes from a pin.
`timescale 1ns/100ps
`default_nettype none

module synth_divider_status_mux #(
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic CHIP_ENABLE,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire synth_pkg::analog_status_s STATUS_IN,
    output logic REGULATOR_ENABLE,
    output logic OSC_ENABLE,
    output logic [1:0] CRYSTAL_BIAS_CURRENT,
    output logic DIVIDED_REFERENCE_OUTPUT,
    output logic PFD_TICK,
    output logic [7:0] FEEDBACK_INT,
    output logic [14:0] FEEDBACK_FRAC,
    output logic [8:0] DIVIDE_RATIO,
    output logic OUTPUT_HALVING,
    output logic STATUS_MUX_OUTPUT
);
    import synth_pkg::*;

    default clocking dc @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);

    logic ce_meta;
    logic ce_sync;
    logic [31:0] synth_ctrl;
    logic [31:0] ref_ctrl;
    logic [31:0] next_synth_ctrl;
    logic [31:0] next_ref_ctrl;
    logic [31:0] next_rdata;
    logic [15:0] settle_cnt;
    logic [15:0] next_settle_cnt;
    logic settled;
    logic [3:0] half;
    logic [3:0] clk_cnt;
    logic [3:0] next_clk_cnt;
    logic div_out;
    logic next_div_out;
    logic [2:0] rdiv_eff;
    logic [2:0] r_cnt;
    logic [2:0] next_r_cnt;
    logic next_pfd_tick;
    logic [14:0] sd_acc;
    logic [14:0] next_sd_acc;
    logic [8:0] next_ratio;
    logic [2:0] good_cnt;
    logic [2:0] next_good_cnt;
    logic lock;
    logic next_lock;
    logic cal_done_n;
    logic mux_bit;
    logic next_mux_out;
    mux_sel_e mux_sel;

    // Chip enable is a pin, so it passes two flops before anything reads it.
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            ce_meta <= 1'b0;
            ce_sync <= 1'b0;
        end
        else
        begin
            ce_meta <= CHIP_ENABLE;
            ce_sync <= ce_meta;
        end
    end

    // Register writes; a disabled chip holds both words at power-up values.
    always_comb
    begin
        next_synth_ctrl = synth_ctrl;
        next_ref_ctrl = ref_ctrl;
        if (!ce_sync)
        begin
            next_synth_ctrl = `SYNTH_CTRL_RESET;
            next_ref_ctrl = `REF_CTRL_RESET;
        end
        else if (WR && ADDR == `OFS_SYNTH_CTRL)
            next_synth_ctrl = WDATA;
        else if (WR && ADDR == `OFS_REF_CTRL)
            next_ref_ctrl = WDATA;
    end

    // Read mux; unmapped addresses read as zero.
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (RD)
        begin
            unique case (ADDR)
                `OFS_SYNTH_CTRL: next_rdata = synth_ctrl;
                `OFS_REF_CTRL: next_rdata = ref_ctrl;
                `OFS_STATUS: next_rdata = {26'h000_0000, OSC_ENABLE,
                    ~STATUS_IN.tx_mode, STATUS_IN.rssi_settled, lock,
                    cal_done_n, settled};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            synth_ctrl <= `SYNTH_CTRL_RESET;
            ref_ctrl <= `REF_CTRL_RESET;
            RDATA <= 32'h0000_0000;
        end
        else
        begin
            synth_ctrl <= next_synth_ctrl;
            ref_ctrl <= next_ref_ctrl;
            RDATA <= next_rdata;
        end
    end

    // Field decode. The oscillator is gated by chip enable directly, so
    // it stops even though the cleared register has the oscillator bit set.
    assign REGULATOR_ENABLE = ce_sync;
    assign OSC_ENABLE = ce_sync & ref_ctrl[`OSC_EN_BIT];
    assign CRYSTAL_BIAS_CURRENT = ref_ctrl[`XBIAS_MSB:`XBIAS_LSB];
    assign OUTPUT_HALVING = ref_ctrl[`HALVE_BIT];
    assign FEEDBACK_INT = synth_ctrl[`INT_MSB:`INT_LSB];
    assign FEEDBACK_FRAC = synth_ctrl[`FRAC_MSB:`FRAC_LSB];
    assign half = ref_ctrl[`CLKDIV_MSB:`CLKDIV_LSB];
    assign mux_sel = mux_sel_e'(synth_ctrl[`MUXSEL_MSB:`MUXSEL_LSB]);
    assign rdiv_eff = (ref_ctrl[`RDIV_MSB:`RDIV_LSB] == 3'h0) ? 3'h1 :
        ref_ctrl[`RDIV_MSB:`RDIV_LSB];

    // Supply settling timer, restarted by every power-down.
    assign settled = (settle_cnt == SETTLE_CYCLES[15:0]);
    always_comb
    begin
        next_settle_cnt = settle_cnt;
        if (!ce_sync)
            next_settle_cnt = 16'h0000;
        else if (!settled)
            next_settle_cnt = settle_cnt + 16'h0001;
    end

    // Divided reference: the field is the half period in reference cycles,
    // which gives the even ratios 2 to 30 with an exact 50:50 duty. It
    // resets high so that the first edge is a fall, opposite the reference.
    always_comb
    begin
        next_clk_cnt = clk_cnt;
        next_div_out = div_out;
        if (half == 4'h0)
        begin
            next_clk_cnt = 4'h0;
            next_div_out = 1'b0;
        end
        else if (clk_cnt >= half - 4'h1)
        begin
            next_clk_cnt = 4'h0;
            next_div_out = ~div_out;
        end
        else
            next_clk_cnt = clk_cnt + 4'h1;
    end

    // Reference counter and first-order sigma-delta on the feedback ratio.
    // The carry adds one to the integer on a fraction of comparison cycles,
    // so the mean ratio is integer plus fraction over two to the fifteen.
    always_comb
    begin
        next_r_cnt = r_cnt + 3'h1;
        next_pfd_tick = 1'b0;
        next_sd_acc = sd_acc;
        next_ratio = DIVIDE_RATIO;
        if (r_cnt >= rdiv_eff - 3'h1)
        begin
            next_r_cnt = 3'h0;
            next_pfd_tick = 1'b1;
        end
        if (PFD_TICK)
        begin
            {next_ratio[0], next_sd_acc} = {1'b0, sd_acc}
                + {1'b0, FEEDBACK_FRAC};
            next_ratio = {1'b0, FEEDBACK_INT} + {8'h00, next_ratio[0]};
        end
        if (!ce_sync)
        begin
            next_sd_acc = 15'h0000;
            next_r_cnt = 3'h0;
        end
    end

    // Lock detect: five good comparisons in a row set it, only a large error or chip disable
    // clears it; errors in between leave it and break the run.
    always_comb
    begin
        next_good_cnt = good_cnt;
        next_lock = lock;
        if (!ce_sync)
        begin
            next_good_cnt = 3'h0;
            next_lock = 1'b0;
        end
        else if (STATUS_IN.phase_valid)
        begin
            if (STATUS_IN.phase_err_ns < `LOCK_ENTER_NS)
            begin
                if (good_cnt != `LOCK_GOOD_COUNT)
                    next_good_cnt = good_cnt + 3'h1;
                if (good_cnt == `LOCK_GOOD_COUNT - 3'h1)
                    next_lock = 1'b1;
            end
            else
            begin
                next_good_cnt = 3'h0;
                if (STATUS_IN.phase_err_ns >= `LOCK_LEAVE_NS)
                    next_lock = 1'b0;
            end
        end
    end

    // Status mux; the reset select is zero, the supply settled flag.
    assign cal_done_n = ~(STATUS_IN.cal_coarse_busy
        | STATUS_IN.cal_fine_busy);
    always_comb
    begin
        unique case (mux_sel)
            SEL_SUPPLY_SETTLED: mux_bit = settled;
            SEL_CAL_DONE_N: mux_bit = cal_done_n;
            SEL_PLL_LOCK: mux_bit = lock;
            SEL_SIGNAL_LEVEL: mux_bit = STATUS_IN.rssi_settled;
            SEL_DIRECTION: mux_bit = ~STATUS_IN.tx_mode;
            default: mux_bit = 1'b0;
        endcase
        next_mux_out = mux_bit;
    end

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            settle_cnt <= 16'h0000;
            clk_cnt <= 4'h0;
            div_out <= 1'b1;
            r_cnt <= 3'h0;
            PFD_TICK <= 1'b0;
            sd_acc <= 15'h0000;
            DIVIDE_RATIO <= 9'h000;
            good_cnt <= 3'h0;
            lock <= 1'b0;
            STATUS_MUX_OUTPUT <= 1'b0;
        end
        else
        begin
            settle_cnt <= next_settle_cnt;
            clk_cnt <= next_clk_cnt;
            div_out <= next_div_out;
            r_cnt <= next_r_cnt;
            PFD_TICK <= next_pfd_tick;
            sd_acc <= next_sd_acc;
            DIVIDE_RATIO <= next_ratio;
            good_cnt <= next_good_cnt;
            lock <= next_lock;
            STATUS_MUX_OUTPUT <= next_mux_out;
        end
    end
    assign DIVIDED_REFERENCE_OUTPUT = div_out;

    // Helper: cycles since the divide field last changed, saturating at
    // 32. A run that straddles a field change has neither the old nor the
    // new length, so the period check waits until the field has settled.
    logic [5:0] half_age;
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            half_age <= 6'h00;
        else if (next_ref_ctrl[`CLKDIV_MSB:`CLKDIV_LSB] != half)
            half_age <= 6'h00;
        else if (!half_age[5])
            half_age <= half_age + 6'h01;
    end

    // Helper: cycles since the divided reference last changed.
    logic [4:0] run_len;
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
            run_len <= 5'h00;
        else if (next_div_out != div_out)
            run_len <= 5'h00;
        else
            run_len <= run_len + 5'h01;
    end

    // Checks on the outputs against their causes.
    a_osc_off_disabled: assert property (!ce_sync |-> !OSC_ENABLE)
        else $error("oscillator on while chip disabled");
    a_osc_default_on: assert property ($rose(ce_sync) |-> ##1 OSC_ENABLE)
        else $error("oscillator not on after enable");
    a_bias_field: assert property (
        ##1 CRYSTAL_BIAS_CURRENT == $past(next_ref_ctrl[14:13]))
        else $error("bias field not taken from register");
    a_div_half_period: assert property (
        (half != 4'h0 && half_age[5] && $changed(div_out))
        |-> $past(run_len) + 5'h01 == {1'b0, half})
        else $error("divided reference half period wrong");
    a_div_stopped: assert property ((half == 4'h0) [*2] |-> !div_out)
        else $error("divided reference runs at ratio zero");
    a_ce_clears: assert property (!ce_sync |=> ref_ctrl[6:4] == 3'h1
        && ref_ctrl[10:7] == 4'h4 && synth_ctrl == 32'h0000_0000)
        else $error("registers not cleared by chip disable");
    a_pfd_spacing: assert property ((PFD_TICK && rdiv_eff > 3'h1
        && $stable(rdiv_eff)) |=> !PFD_TICK)
        else $error("comparison ticks too close");
    // The ratio is built from the integer seen at the tick, so compare
    // against that value; a write in the same cycle must not trip it.
    a_ratio_range: assert property (PFD_TICK && $stable(FEEDBACK_INT)
        |=> (DIVIDE_RATIO == {1'b0, $past(FEEDBACK_INT)}
        || DIVIDE_RATIO == {1'b0, $past(FEEDBACK_INT)} + 9'h001))
        else $error("divide ratio not integer or integer plus one");
    // Read data stand for one cycle after a read strobe and are zero else.
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
        else $error("read data present without a read strobe");
    a_lock_drop: assert property ((ce_sync && STATUS_IN.phase_valid
        && STATUS_IN.phase_err_ns >= 8'h19) |=> !lock)
        else $error("lock held through large phase error");
    a_lock_needs_five: assert property ($rose(lock) |-> $past(good_cnt)
        == 3'h4)
        else $error("lock set before five good cycles");
    a_mux_settled: assert property ((mux_sel == SEL_SUPPLY_SETTLED)
        |=> STATUS_MUX_OUTPUT == $past(settled))
        else $error("status output does not show supply settled");
    a_cal_low: assert property ((mux_sel == SEL_CAL_DONE_N
        && STATUS_IN.cal_fine_busy) |=> !STATUS_MUX_OUTPUT)
        else $error("calibration done high during calibration");
    a_direction: assert property ((mux_sel == SEL_DIRECTION)
        |=> STATUS_MUX_OUTPUT == !$past(STATUS_IN.tx_mode))
        else $error("direction indicator wrong");

    c_lock_seen: cover property ($rose(lock));
    c_lock_lost: cover property ($fell(lock));
    c_settled_seen: cover property ($rose(settled));
    c_div_toggle: cover property ($fell(div_out) ##[1:30] $rose(div_out));
    c_ratio_carry: cover property (PFD_TICK ##1
        DIVIDE_RATIO != {1'b0, FEEDBACK_INT});
endmodule : synth_divider_status_mux

`default_nettype wire

// ---- src/synth_pkg.sv ----
// Types shared by the synthesizer control block and its bench.
// Assumes the constants header is on the include path.
package synth_pkg;
    `include "synth_regs.svh"

    // Status sources on the multiplexed status output.
    typedef enum logic [2:0] {
        SEL_SUPPLY_SETTLED,
        SEL_CAL_DONE_N,
        SEL_PLL_LOCK,
        SEL_SIGNAL_LEVEL,
        SEL_DIRECTION
    } mux_sel_e;

    // Indications from the analog and modem sections, on CLK_SYS.
    typedef struct packed {
        logic cal_coarse_busy;
        logic cal_fine_busy;
        logic rssi_settled;
        logic tx_mode;
        logic phase_valid;
        logic [7:0] phase_err_ns;
    } analog_status_s;
endpackage : synth_pkg

// ---- src/synth_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the
// synthesizer control block. Included by the package; the design sees its macros through it.
//
// Behaviour
// - Oscillator on per bit 12, default on, off when chip disabled
// - Two-bit crystal bias field at bits 13-14
// - Divided reference: 50:50 square, inverted to reference
// - Divided reference divides evenly 2 to 30
// - Divided reference defaults to divide by eight
// - Divide field zero stops the divided reference
// - Three-bit reference counter divides by 1 to 7
// - Reference ratio from bits 4-6, default one
// - Reference ratio returns to one on initialisation
// - Eight-bit feedback integer from register 0 bits 19-26
// - Fifteen-bit feedback fraction drives sigma-delta modulator
// - Frequency equals comparison clock times integer plus fraction
// - Output halving multiplies output frequency by one half
// - Chip enable low powers down and clears registers
// - Status select bits 29-31, default supply settled flag
// - Calibration done low throughout both filter calibrations
// - Lock after five cycles under 15 ns, drops at 25
// - Signal level valid once strength measurement has settled
// - Direction indicator low transmitting, high receiving
`ifndef SYNTH_REGS_SVH
`define SYNTH_REGS_SVH

`define OFS_SYNTH_CTRL 8'h00
`define OFS_REF_CTRL 8'h04
`define OFS_STATUS 8'h08

`define FRAC_LSB 4
`define FRAC_MSB 18
`define INT_LSB 19
`define INT_MSB 26
`define MUXSEL_LSB 29
`define MUXSEL_MSB 31

`define RDIV_LSB 4
`define RDIV_MSB 6
`define CLKDIV_LSB 7
`define CLKDIV_MSB 10
`define OSC_EN_BIT 12
`define XBIAS_LSB 13
`define XBIAS_MSB 14
`define HALVE_BIT 18

`define SYNTH_CTRL_RESET 32'h0000_0000
`define REF_CTRL_RESET 32'h0000_1210

`define CLK_MHZ 100
`define SETTLE_TIME_US 50
`define SETTLE_CYCLES (`SETTLE_TIME_US * `CLK_MHZ)
`define LOCK_GOOD_COUNT 3'h5
`define LOCK_ENTER_NS 8'h0F
`define LOCK_LEAVE_NS 8'h19

`endif

// ---- tb/synth_analog_model.sv ----
// Behavioural analog and modem section that feeds the status inputs.
// Assumes the bench sets the levels and the phase error that it wants.
`timescale 1ns/100ps
`default_nettype none

module synth_analog_model (
    input wire logic clk,
    input wire logic pfd_tick,
    input wire logic [7:0] err_ns,
    input wire logic [2:0] levels,
    output synth_pkg::analog_status_s status
);
    import synth_pkg::*;

    // Start quiet so that no input of the block is unknown at time zero.
    initial status = '0;

    // One phase measurement follows every comparison tick, as a PFD does.
    always @(posedge clk)
    begin
        status.phase_valid <= pfd_tick;
        status.phase_err_ns <= err_ns;
        status.cal_coarse_busy <= levels[0];
        status.cal_fine_busy <= levels[0];
        status.rssi_settled <= levels[1];
        status.tx_mode <= levels[2];
    end
endmodule : synth_analog_model

`default_nettype wire

// ---- tb/synth_divider_status_mux_tb.sv ----
// Self-checking bench of the synthesizer control and status block.
// Assumes a settle count of 20 cycles so that the run stays short.
`timescale 1ns/100ps
`default_nettype none

module synth_divider_status_mux_tb;
    import synth_pkg::*;

    logic clk, rstn, ce, wr, rd, reg_en, osc_en, dref, tick, halve, smux;
    logic [7:0] addr, err_ns, f_int;
    logic [31:0] wdata, rdata, got, s;
    logic [2:0] levels;
    logic [1:0] bias;
    logic [14:0] f_frac;
    logic [8:0] ratio;
    logic [6:0] tab [7];
    analog_status_s st;
    int num_errors, cmp_count, n;

    synth_divider_status_mux #(.SETTLE_CYCLES(20)) u_dut (
        .CLK_SYS(clk), .RSTN(rstn), .CHIP_ENABLE(ce), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .STATUS_IN(st),
        .REGULATOR_ENABLE(reg_en), .OSC_ENABLE(osc_en),
        .CRYSTAL_BIAS_CURRENT(bias), .DIVIDED_REFERENCE_OUTPUT(dref),
        .PFD_TICK(tick), .FEEDBACK_INT(f_int), .FEEDBACK_FRAC(f_frac),
        .DIVIDE_RATIO(ratio), .OUTPUT_HALVING(halve),
        .STATUS_MUX_OUTPUT(smux)
    );

    synth_analog_model u_model (
        .clk(clk), .pfd_tick(tick), .err_ns(err_ns), .levels(levels),
        .status(st)
    );

    // Free-running 100 MHz reference clock.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe.
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        got = rdata;
    endtask : rd_reg

    // Length in cycles of the next complete run of level v on the output.
    task automatic run(input logic v);
        cyc(1);
        repeat (80) if (dref === v) cyc(1); else break;
        repeat (80) if (dref !== v) cyc(1); else break;
        n = 0;
        while (dref === v && n < 40)
        begin
            cyc(1);
            n++;
        end
    endtask : run

    task automatic tick_gap();
        cyc(1);
        repeat (20) if (tick !== 1'b1) cyc(1); else break;
        n = 0;
        do
        begin
            cyc(1);
            n++;
        end while (tick !== 1'b1 && n < 20);
    endtask : tick_gap

    task automatic test_reset();
        rd_reg(8'h00);
        chk(got, 32'h0000_0000);
        rd_reg(8'h04);
        chk(got, 32'h0000_1000 | (4 << 7) | (1 << 4));
        cyc(1);
        chk(rdata, 32'h0000_0000);
        rd_reg(8'h0C);
        chk(got, 32'h0000_0000);
        chk(osc_en, 1'b1);
        // The host holds off programming until the supply reports settled.
        repeat (100) if (smux !== 1'b1) cyc(1); else break;
        chk(smux, 1'b1);
        // Settled, calibration idle, unlocked, receiving, oscillator on.
        rd_reg(8'h08);
        chk(got, 32'h0000_0033);
        $display("test reset done");
    endtask : test_reset

    task automatic test_divided_reference_output();
        run(1'b1);
        chk(n, 4);
        run(1'b0);
        chk(n, 4);
        wr_reg(8'h04, 32'h0000_1000 | (15 << 7) | (1 << 4));
        run(1'b1);
        chk(n, 15);
        run(1'b0);
        chk(n, 15);
        wr_reg(8'h04, 32'h0000_1000 | (1 << 7) | (1 << 4));
        run(1'b1);
        chk(n, 1);
        wr_reg(8'h04, 32'h0000_1010);
        cyc(3);
        chk(dref, 1'b0);
        cyc(40);
        chk(dref, 1'b0);
        $display("test divided_reference_output done");
    endtask : test_divided_reference_output

    task automatic test_refdiv();
        foreach (tab[i]) tab[i] = 7'(i % 3 == 0 ? 2 : (i % 3 == 1 ? 7 : 1));
        for (int i = 0; i < 3; i++)
        begin
            wr_reg(8'h04, 32'h0000_1000 | (tab[i] << 4));
            tick_gap();
            chk(n, tab[i]);
        end
        $display("test refdiv done");
    endtask : test_refdiv

    task automatic test_feedback();
        wr_reg(8'h00, (200 << 19) | (32'h0000_4000 << 4));
        cyc(4);
        chk(f_int, 200);
        chk(f_frac, 15'h4000);
        // Half a fraction alternates the ratio between int and int plus one.
        s = ratio;
        cyc(1);
        s = s + ratio;
        chk(s, 401);
        wr_reg(8'h04, 32'h0004_6000 | (4 << 7) | (1 << 4));
        cyc(2);
        chk(halve, 1'b1);
        chk(bias, 2'b11);
        chk(osc_en, 1'b0);
        $display("test feedback done");
    endtask : test_feedback

    task automatic test_status();
        tab = '{7'b001_001_0, 7'b001_000_1, 7'b011_010_1, 7'b011_000_0,
                7'b100_100_0, 7'b100_000_1, 7'b101_000_0};
        foreach (tab[i])
        begin
            wr_reg(8'h00, {tab[i][6:4], 29'(200 << 19)});
            levels <= tab[i][3:1];
            cyc(4);
            chk(smux, tab[i][0]);
        end
        wr_reg(8'h00, {3'h2, 29'(200 << 19)});
        err_ns <= 8'h03;
        cyc(12);
        chk(smux, 1'b1);
        err_ns <= 8'h18;
        cyc(8);
        chk(smux, 1'b1);
        err_ns <= 8'h19;
        cyc(4);
        chk(smux, 1'b0);
        err_ns <= 8'h0F;
        cyc(12);
        chk(smux, 1'b0);
        err_ns <= 8'h0E;
        cyc(3);
        chk(smux, 1'b0);
        cyc(8);
        chk(smux, 1'b1);
        $display("test status done");
    endtask : test_status

    task automatic test_ce();
        ce <= 1'b0;
        cyc(5);
        chk(reg_en, 1'b0);
        chk(osc_en, 1'b0);
        ce <= 1'b1;
        cyc(5);
        chk(reg_en, 1'b1);
        rd_reg(8'h04);
        chk(got, 32'h0000_1210);
        rd_reg(8'h00);
        chk(got, 32'h0000_0000);
        $display("test chip enable done");
    endtask : test_ce

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    // Cuts a hang short; the tests need well under a tenth of this span.
    initial
    begin
        #100000;
        num_errors++;
        print_verdict();
    end

    // Main sequence: reset, then each scenario in turn.
    initial
    begin
        {rstn, wr, rd, addr, wdata, levels} = '0;
        ce = 1'b1;
        err_ns = 8'h30;
        num_errors = 0;
        cmp_count = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        cyc(1);
        test_reset();
        test_divided_reference_output();
        test_refdiv();
        test_feedback();
        test_status();
        test_ce();
        print_verdict();
    end
endmodule : synth_divider_status_mux_tb

`default_nettype wire
